// *** rtl/nvsrc_ctrl.sv ***
// Store/recall control and burst access for a serial nonvolatile SRAM.
// Assumes a frame decoder supplies address/data byte strobes and commands.
// Summary of operation
// - Burst write increments address, wraps to zero
// - Burst read increments address, wraps to zero
// - Accesses complete without wait cycles
// - Save erases then programs nonvolatile
// - Save refuses all memory accesses
// - Busy pin low and busy flag set
// - Power-down and pin saves need a write
// - Commanded save runs when idle, even with no write
// - Power fail blocks access; the first one since reset, if idle, starts conditional save
// - Pin request starts conditional save after delay
// - Pin save blocks while pin stays low
// - Pull pin low, drive high briefly, release
// - Access blocked release interval after pin high
// - Restore clears then copies, nonvolatile unchanged
// - Power-up starts restore, blocks access
// - Autosave off/on commands, volatile setting
// - Power-up restore cannot be disabled
// - Cells start 0x00, autosave enabled
// - Only low 17 address bits used
`timescale 1ns/1ps
module nvsrc_ctrl #(
  parameter int STORE_CYCLES = nvsrc_pkg::STORE_CYC,
  parameter int RECALL_CYCLES = nvsrc_pkg::RECALL_CYC,
  parameter int POWERUP_CYCLES = nvsrc_pkg::POWERUP_RESTORE_CYC,
  parameter int FIFO_DEPTH_P = nvsrc_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Access from the frame decoder
  input wire logic start_i,
  input wire logic is_write_i,
  input wire logic [nvsrc_pkg::ADDR_FIELD_W-1:0] addr_i,
  input wire logic wr_valid_i,
  input wire logic [nvsrc_pkg::DATA_W-1:0] wr_data_i,
  output logic wr_ready_o,
  input wire logic rd_req_i,
  output logic [nvsrc_pkg::DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic access_refused_o,
  // Commands, one-cycle pulses
  input wire logic save_cmd_i,
  input wire logic restore_cmd_i,
  input wire logic autosave_off_command_i,
  input wire logic autosave_on_command_i,
  // Power monitor
  input wire logic power_fail_i,
  // Busy/request pin, open drain with brief high drive
  input wire logic save_busy_request_pin_i,
  output logic save_busy_request_pin_o,
  output logic save_busy_request_pin_oe_n_o,
  // Status
  output logic busy_flag_o,
  output logic autosave_en_o,
  output logic dirty_o,
  // Nonvolatile array image port
  output logic nv_erase_o,
  output logic nv_program_o,
  output logic nv_copy_o
);
  import nvsrc_pkg::*;
  localparam int FW = ADDR_W + DATA_W;

  typedef struct packed {
    nvsrc_state_e state;
    logic [CNT_W+8:0] cnt;
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] rd_addr;
    logic dirty;
    logic autosave;
    logic from_pin;
    logic pf_seen;
    logic pin_low_q;
    logic [DATA_W-1:0] rd_data;
    logic rd_valid;
  } nvsrc_s;

  nvsrc_s st, next_st;
  logic [DATA_W-1:0] sram [2**ADDR_W];
  // Image as delivered: every cell holds the reset pattern
  logic [DATA_W-1:0] nv [2**ADDR_W] = '{default: CELL_RESET};
  logic blocked, pin_low, f_valid, f_ready, f_out_valid, f_out_ready;
  logic [FW-1:0] f_in, f_out;
  logic sram_we, clr_we;

  assign pin_low = !save_busy_request_pin_i;
  assign blocked = st.state != NVSRC_IDLE || power_fail_i;

  nvsrc_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH_P)) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(f_valid),
    .in_ready_o(f_ready),
    .in_data_i(f_in),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_out_ready),
    .out_data_o(f_out)
  );
  // Drain only while idle; a byte still queued when a save starts is written after that save
  assign f_valid = wr_valid_i && !blocked;
  assign wr_ready_o = f_ready && !blocked;
  assign f_in = {st.wr_addr, wr_data_i};
  assign f_out_ready = !blocked;
  assign sram_we = f_out_valid && f_out_ready;
  assign clr_we = st.state == NVSRC_CLEAR;
  assign access_refused_o = blocked && (start_i || wr_valid_i || rd_req_i);

  always_comb begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    next_st.pin_low_q = pin_low;
    if (power_fail_i) next_st.pf_seen = 1'b1;
    if (autosave_off_command_i) next_st.autosave = 1'b0;
    if (autosave_on_command_i) next_st.autosave = 1'b1;
    if (!blocked) begin
      if (start_i) begin
        next_st.wr_addr = addr_i[ADDR_W-1:0];
        next_st.rd_addr = addr_i[ADDR_W-1:0];
      end else begin
        if (wr_valid_i && f_ready)
          next_st.wr_addr = st.wr_addr + 1'b1;
        if (rd_req_i) begin
          next_st.rd_data = sram[st.rd_addr];
          next_st.rd_valid = 1'b1;
          next_st.rd_addr = st.rd_addr + 1'b1;
        end
      end
    end
    if (sram_we) next_st.dirty = 1'b1;
    case (st.state)
      NVSRC_IDLE: begin
        next_st.cnt = '0;
        if (save_cmd_i) begin
          next_st.state = NVSRC_ERASE;
          next_st.from_pin = 1'b0;
        end else if (power_fail_i && !st.pf_seen) begin
          if (st.autosave && st.dirty) begin
            next_st.state = NVSRC_ERASE;
            next_st.from_pin = 1'b0;
          end
        end else if (pin_low && !st.pin_low_q) begin
          next_st.state = NVSRC_REQ_WAIT;
        end else if (restore_cmd_i) begin
          next_st.state = NVSRC_CLEAR;
          // Commanded restore uses the short copy time
          next_st.from_pin = 1'b0;
        end
      end
      NVSRC_REQ_WAIT: begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt >= (CNT_W+9)'(REQ_DELAY_CYC - 1)) begin
          next_st.cnt = '0;
          next_st.from_pin = 1'b1;
          next_st.state = st.dirty ? NVSRC_ERASE : NVSRC_RELEASE;
        end
      end
      NVSRC_ERASE: begin
        next_st.state = NVSRC_PROGRAM;
      end
      NVSRC_PROGRAM: begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt >= (CNT_W+9)'(STORE_CYCLES - 2)) begin
          next_st.cnt = '0;
          next_st.dirty = sram_we;
          next_st.state = NVSRC_DRIVE_HIGH;
        end
      end
      NVSRC_DRIVE_HIGH: begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt >= (CNT_W+9)'(DRIVE_HIGH_CYC - 1)) begin
          next_st.cnt = '0;
          next_st.state = NVSRC_RELEASE;
        end
      end
      NVSRC_RELEASE: begin
        // Count restarts while an outside party holds the pin low
        next_st.cnt = pin_low ? '0 : st.cnt + 1'b1;
        if (!pin_low && st.cnt >= (CNT_W+9)'(RELEASE_CYC - 1)) begin
          next_st.cnt = '0;
          next_st.state = NVSRC_IDLE;
        end
      end
      NVSRC_CLEAR: begin
        // Whole array clears in one cycle, copy follows
        next_st.state = NVSRC_COPY;
        next_st.cnt = '0;
      end
      NVSRC_COPY: begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt >= (CNT_W+9)'((st.from_pin ? POWERUP_CYCLES
                                   : RECALL_CYCLES) - 1)) begin
          next_st.cnt = '0;
          next_st.dirty = 1'b0;
          next_st.from_pin = 1'b0;
          next_st.state = NVSRC_IDLE;
        end
      end
      default: next_st.state = NVSRC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.state <= NVSRC_CLEAR;
      st.from_pin <= 1'b1;
      st.autosave <= AUTOSAVE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Clear and copy are single-cycle image transfers, not per-cell walks
  always_ff @(posedge clk_i) begin
    if (clr_we) sram <= '{default: CELL_RESET};
    else if (sram_we) sram[f_out[FW-1:DATA_W]] <= f_out[DATA_W-1:0];
    if (st.state == NVSRC_PROGRAM && st.cnt == '0)
      nv <= sram;
    if (st.state == NVSRC_COPY && st.cnt == '0)
      sram <= nv;
  end

  assign rd_data_o = st.rd_data;
  assign rd_valid_o = st.rd_valid;
  assign nv_erase_o = st.state == NVSRC_ERASE;
  assign nv_program_o = st.state == NVSRC_PROGRAM;
  assign nv_copy_o = st.state == NVSRC_COPY;
  assign busy_flag_o = st.state inside {NVSRC_ERASE, NVSRC_PROGRAM,
                                        NVSRC_CLEAR, NVSRC_COPY};
  // Low during save or restore, driven high after save, else released
  assign save_busy_request_pin_o = !busy_flag_o;
  assign save_busy_request_pin_oe_n_o =
    !(busy_flag_o || st.state == NVSRC_DRIVE_HIGH);
  assign autosave_en_o = st.autosave;
  assign dirty_o = st.dirty;
endmodule // nvsrc_ctrl

// *** rtl/nvsrc_fifo.sv ***
// Write-data FIFO in front of the array port.
// Assumes one clock, synchronous valid/ready on both sides.
`timescale 1ns/1ps
module nvsrc_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [PW:0] cnt;
  } nvsrc_fifo_s;
  nvsrc_fifo_s st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;
  assign in_ready_o = st.cnt != (PW+1)'(DEPTH);
  assign out_valid_o = st.cnt != '0;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[st.rd];
  always_comb begin
    next_st = st;
    if (push) next_st.wr = st.wr + 1'b1;
    if (pop) next_st.rd = st.rd + 1'b1;
    next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) st <= '0;
    else st <= next_st;
  end
  always_ff @(posedge clk_i) begin
    if (push) mem[st.wr] <= in_data_i;
  end
endmodule // nvsrc_fifo

// *** rtl/nvsrc_pkg.sv ***
// Package for the nonvolatile store/recall controller.
// Assumes a 50 MHz system clock; all times converted to cycles here.
package nvsrc_pkg;
  localparam int CLK_MHZ = 50;
  localparam int ADDR_W = 17;
  localparam int ADDR_FIELD_W = 24;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_WRAP = 17'h00000;
  localparam logic [DATA_W-1:0] CELL_RESET = 8'h00;
  localparam logic AUTOSAVE_RESET = 1'b1;
  // Times in microseconds, as printed figures are not given
  localparam int STORE_TIME_US = 8000;
  localparam int RECALL_TIME_US = 200;
  localparam int POWERUP_RESTORE_US = 20000;
  localparam int REQ_DELAY_US = 1;
  localparam int DRIVE_HIGH_US = 1;
  localparam int RELEASE_US = 1;
  localparam int STORE_CYC = STORE_TIME_US * CLK_MHZ;
  localparam int RECALL_CYC = RECALL_TIME_US * CLK_MHZ;
  localparam int POWERUP_RESTORE_CYC = POWERUP_RESTORE_US * CLK_MHZ;
  localparam int REQ_DELAY_CYC = REQ_DELAY_US * CLK_MHZ;
  localparam int DRIVE_HIGH_CYC = DRIVE_HIGH_US * CLK_MHZ;
  localparam int RELEASE_CYC = RELEASE_US * CLK_MHZ;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 21;
  typedef enum logic [3:0] {
    NVSRC_IDLE, NVSRC_REQ_WAIT, NVSRC_ERASE, NVSRC_PROGRAM,
    NVSRC_DRIVE_HIGH, NVSRC_RELEASE, NVSRC_CLEAR, NVSRC_COPY
  } nvsrc_state_e;
endpackage

// *** sim/nvsrc_pin_model.sv ***
// Busy/request wire with pull-up and external requester.
// Assumes the device enable is low while it drives.
`timescale 1ns/1ps
module nvsrc_pin_model (
  // Device side
  input wire logic dev_o_i,
  input wire logic dev_oe_n_i,
  // Requester side
  input wire logic pull_low_i,
  // Wire level
  output logic pin_o
);
  // A requester pull-low overrides any device drive
  assign pin_o = pull_low_i ? 1'b0 : (!dev_oe_n_i ? dev_o_i : 1'b1);
endmodule // nvsrc_pin_model

// *** sim/nvsrc_properties.sv ***
// Port checker for the store/recall controller.
// Assumes bind onto nvsrc_ctrl; one clock domain.
`timescale 1ns/1ps
module nvsrc_properties (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic rd_req_i,
  input wire logic wr_valid_i,
  input wire logic wr_ready_o,
  input wire logic rd_valid_o,
  input wire logic access_refused_o,
  input wire logic autosave_off_command_i,
  input wire logic autosave_on_command_i,
  input wire logic save_busy_request_pin_o,
  input wire logic save_busy_request_pin_oe_n_o,
  input wire logic busy_flag_o,
  input wire logic autosave_en_o,
  input wire logic dirty_o,
  input wire logic nv_erase_o,
  input wire logic nv_program_o,
  input wire logic nv_copy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence write_s; wr_valid_i && wr_ready_o; endsequence
  sequence erase_s; nv_erase_o; endsequence
  busy_pin_low_a: assert property (
    busy_flag_o |-> !save_busy_request_pin_oe_n_o && !save_busy_request_pin_o)
    else $error("pin not low while busy");
  busy_refuse_a: assert property (
    busy_flag_o && (start_i || rd_req_i || wr_valid_i) |-> access_refused_o)
    else $error("access not refused while busy");
  busy_no_ready_a: assert property (busy_flag_o |-> !wr_ready_o)
    else $error("write ready while busy");
  read_answer_a: assert property (
    rd_req_i && !busy_flag_o && !access_refused_o |=> rd_valid_o)
    else $error("read byte late");
  erase_then_program_a: assert property (
    $rose(nv_program_o) |-> $past(nv_erase_o))
    else $error("program without erase");
  copy_alone_a: assert property (
    nv_copy_o |-> !nv_erase_o && !nv_program_o && busy_flag_o)
    else $error("copy overlaps save");
  dirty_set_a: assert property (write_s |-> ##[1:12] dirty_o)
    else $error("write left flag clear");
  autosave_off_a: assert property (
    autosave_off_command_i |=> !autosave_en_o)
    else $error("autosave still on");
  autosave_on_a: assert property (
    autosave_on_command_i |=> autosave_en_o)
    else $error("autosave still off");
  pin_drive_high_a: assert property (
    $fell(nv_program_o) |-> !save_busy_request_pin_oe_n_o
      && save_busy_request_pin_o)
    else $error("pin not driven high after save");
  save_cover_c: cover property (erase_s ##1 nv_program_o);
endmodule // nvsrc_properties
bind nvsrc_ctrl nvsrc_properties nvsrc_properties_inst (.*);

// *** sim/testbench.sv ***
// Self-checking bench for the store/recall controller.
// Assumes the pin model resolves the busy/request wire.
`timescale 1ns/1ps
module testbench;
  import nvsrc_pkg::*;
  logic clk_i = 0, rst_n_i = 0, start_i = 0, is_write_i = 0, rd_req_i = 0;
  logic [ADDR_FIELD_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wr_data_i = '0, rd_data_o;
  logic wr_valid_i = 0, save_cmd_i = 0, restore_cmd_i = 0, as_off = 0;
  logic as_on = 0, power_fail_i = 0, pull_low = 0, pin, pin_o, pin_oe_n;
  logic wr_ready_o, rd_valid_o, access_refused_o, busy_flag_o;
  logic autosave_en_o, dirty_o, nv_erase_o, nv_program_o, nv_copy_o;
  int mismatches = 0, check_count = 0;
  always #10 clk_i = ~clk_i;
  nvsrc_ctrl #(.STORE_CYCLES(40), .RECALL_CYCLES(30), .POWERUP_CYCLES(50))
  nvsrc_ctrl_inst (.clk_i, .rst_n_i, .start_i, .is_write_i, .addr_i,
    .wr_valid_i, .wr_data_i, .wr_ready_o, .rd_req_i, .rd_data_o, .rd_valid_o,
    .access_refused_o, .save_cmd_i, .restore_cmd_i,
    .autosave_off_command_i(as_off), .autosave_on_command_i(as_on),
    .power_fail_i, .save_busy_request_pin_i(pin),
    .save_busy_request_pin_o(pin_o), .save_busy_request_pin_oe_n_o(pin_oe_n),
    .busy_flag_o, .autosave_en_o, .dirty_o, .nv_erase_o, .nv_program_o,
    .nv_copy_o);
  nvsrc_pin_model nvsrc_pin_model_inst (.dev_o_i(pin_o),
    .dev_oe_n_i(pin_oe_n), .pull_low_i(pull_low), .pin_o(pin));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return busy_flag_o;
      1: return rd_valid_o;
      2: return wr_ready_o;
      3: return nv_program_o;
      default: return nv_copy_o;
    endcase
  endfunction
  task automatic wait_for(input int s, input logic lvl, input int lim);
    int n = 0;
    while (sig(s) !== lvl) begin
      @(negedge clk_i);
      n++;
      if (n > lim) begin
        mismatches++;
        $display("wrong value at %0t: wait %0d hung", $time, s);
        report_and_stop();
      end
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic frame(input logic [23:0] a);
    start_i = 1;
    addr_i = a;
    idle(1);
    start_i = 0;
  endtask
  // Caller lowers valid, so back-to-back bytes keep it high between them
  task automatic wr(input logic [7:0] d);
    wr_valid_i = 1;
    wr_data_i = d;
    wait_for(2, 1, 20);
    idle(1);
  endtask
  task automatic rd(input logic [7:0] exp, input string m);
    rd_req_i = 1;
    idle(1);
    rd_req_i = 0;
    wait_for(1, 1, 2);
    chk(rd_data_o, exp, m);
    idle(1);
  endtask
  task automatic write1(input logic [23:0] a, input logic [7:0] d);
    frame(a);
    wr(d);
    wr_valid_i = 0;
    idle(12);
  endtask
  task automatic t_powerup();
    chk(busy_flag_o, 1, "no busy at power-up");
    chk(pin, 0, "pin high during restore");
    wait_for(0, 0, 200);
    idle(60);
    chk(autosave_en_o, 1, "autosave default");
    frame(24'h000010);
    rd(8'h00, "cell default");
    $display("test powerup done");
  endtask
  task automatic t_burst();
    frame(24'hFFFFFF);
    wr(8'hA5);
    wr(8'h5A);
    wr_valid_i = 0;
    idle(12);
    frame(24'h01FFFF);
    rd(8'hA5, "top address");
    rd(8'h5A, "wrap to zero");
    $display("test burst done");
  endtask
  task automatic t_save_restore();
    write1(24'h000005, 8'h3C);
    chk(dirty_o, 1, "flag after write");
    save_cmd_i = 1;
    idle(1);
    save_cmd_i = 0;
    chk(nv_erase_o, 1, "no erase first");
    start_i = 1;
    #1 chk(access_refused_o, 1, "access during save");
    idle(1);
    start_i = 0;
    wait_for(3, 1, 100);
    wait_for(0, 0, 100);
    chk({pin, pin_oe_n}, 8'h02, "pin not driven high");
    chk(dirty_o, 0, "flag after save");
    start_i = 1;
    #1 chk(access_refused_o, 1, "access before release");
    idle(1);
    start_i = 0;
    // Drive-high and release intervals must pass before a new command
    idle(104);
    save_cmd_i = 1;
    idle(1);
    save_cmd_i = 0;
    chk(busy_flag_o, 1, "clean save skipped");
    wait_for(0, 0, 100);
    idle(110);
    write1(24'h000005, 8'hC3);
    restore_cmd_i = 1;
    idle(1);
    restore_cmd_i = 0;
    chk(busy_flag_o, 1, "restore not busy");
    wait_for(4, 1, 200);
    wait_for(0, 0, 200);
    idle(60);
    frame(24'h000005);
    rd(8'h3C, "restored value");
    $display("test save restore done");
  endtask
  task automatic t_pin();
    pull_low = 1;
    idle(REQ_DELAY_CYC + 10);
    chk(busy_flag_o, 0, "clean pin save ran");
    pull_low = 0;
    idle(60);
    write1(24'h000020, 8'h77);
    pull_low = 1;
    wait_for(0, 1, REQ_DELAY_CYC + 20);
    rd_req_i = 1;
    #1 chk(access_refused_o, 1, "read during pin save");
    idle(1);
    rd_req_i = 0;
    pull_low = 0;
    wait_for(0, 0, 100);
    idle(110);
    $display("test pin done");
  endtask
  task automatic t_power();
    as_off = 1;
    idle(1);
    as_off = 0;
    chk(autosave_en_o, 0, "autosave still on");
    // Autosave only with a capacitor, so the on command sets it back at once
    as_on = 1;
    idle(1);
    as_on = 0;
    chk(autosave_en_o, 1, "autosave still off");
    write1(24'h000030, 8'h11);
    power_fail_i = 1;
    start_i = 1;
    #1 chk(access_refused_o, 1, "access in power fail");
    idle(1);
    start_i = 0;
    wait_for(0, 1, 20);
    $display("test power done");
  endtask
  initial begin
    idle(6);
    rst_n_i = 1;
    idle(1);
    t_powerup();
    t_burst();
    t_save_restore();
    t_pin();
    t_power();
    report_and_stop();
  end
endmodule // testbench
